// ### src/usss_pkg.sv
// package for the synchronous slave serial port: register map, bit
// positions, reset values and the carrier types used across the design.
// assumes an 8-bit register port driven by a core on the same clock.
package usss_pkg;

  // register width and address width of the plain register port
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 4;

  // register indices on the register port
  localparam logic [3:0] ADDR_INTERRUPT_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_IRQ_FLAGS_ONE = 4'h1;
  localparam logic [3:0] ADDR_IRQ_ENABLES_ONE = 4'h2;
  localparam logic [3:0] ADDR_IRQ_PRIORITY_ONE = 4'h3;
  localparam logic [3:0] ADDR_RECEIVE_STATUS_CONTROL = 4'h4;
  localparam logic [3:0] ADDR_TRANSMIT_HOLDING = 4'h5;
  localparam logic [3:0] ADDR_TRANSMIT_STATUS_CONTROL = 4'h6;
  localparam logic [3:0] ADDR_BAUD_CONTROL = 4'h7;
  localparam logic [3:0] ADDR_BAUD_DIVISOR_HIGH = 4'h8;
  localparam logic [3:0] ADDR_BAUD_DIVISOR_LOW = 4'h9;
  localparam logic [3:0] ADDR_RECEIVE_BUFFER = 4'hA;

  // interrupt control bits
  localparam int unsigned BIT_GLOBAL_IRQ_EN = 7;
  localparam int unsigned BIT_PERIPH_IRQ_EN = 6;
  // peripheral flag / enable bits
  localparam int unsigned BIT_RX_COMPLETE = 5;
  localparam int unsigned BIT_TX_EMPTY = 4;
  // receive status and control bits
  localparam int unsigned BIT_PORT_ENABLE = 7;
  localparam int unsigned BIT_RX_NINE = 6;
  localparam int unsigned BIT_SINGLE_RX_EN = 5;
  localparam int unsigned BIT_CONT_RX_EN = 4;
  localparam int unsigned BIT_FRAMING_ERR = 2;
  localparam int unsigned BIT_OVERRUN_ERR = 1;
  localparam int unsigned BIT_RX_NINTH_DATA = 0;
  // transmit status and control bits
  localparam int unsigned BIT_CLOCK_SOURCE = 7;
  localparam int unsigned BIT_TX_NINE = 6;
  localparam int unsigned BIT_TX_ENABLE = 5;
  localparam int unsigned BIT_CLOCKED_MODE = 4;
  localparam int unsigned BIT_SHIFT_EMPTY = 1;
  localparam int unsigned BIT_TX_NINTH_DATA = 0;
  // baud control: receive idle status bit
  localparam int unsigned BIT_RX_IDLE = 6;

  // masks: which bits software may store in each register
  localparam logic [7:0] MASK_FLAGS_SW = 8'hCF;
  localparam logic [7:0] MASK_RECEIVE_STATUS_CONTROL_SW = 8'hF8;
  localparam logic [7:0] MASK_TRANSMIT_STATUS_CONTROL_SW = 8'hFD;
  localparam logic [7:0] MASK_BAUD_SW = 8'h9B;

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [8:0] RESET_WORD = 9'h000;
  localparam logic [3:0] RESET_COUNT = 4'h0;

  // word lengths in bits
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;

  // register port request from the core
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } usss_req_t;

  // complete state of the port
  typedef struct packed {
    logic ck_s1;         // shift clock synchroniser, first stage
    logic ck_s2;         // shift clock synchroniser, second stage
    logic ck_prev;       // delayed second stage for edge finding
    logic dt_s1;         // data pin synchroniser, first stage
    logic dt_s2;         // data pin synchroniser, second stage
    logic [7:0] interrupt_control;  // interrupt control
    logic [7:0] flags;   // software bits of the flag register
    logic [7:0] pie;     // peripheral interrupt enables
    logic [7:0] ipr;     // peripheral interrupt priorities
    logic [7:0] receive_status_control;   // software bits of receive status/control
    logic [7:0] transmit_status_control;   // software bits of transmit status/control
    logic [7:0] baud;    // software bits of baud control
    logic [7:0] div_hi;  // divisor high, unused in slave mode
    logic [7:0] div_lo;  // divisor low, unused in slave mode
    logic [8:0] hold;    // transmit holding word with ninth bit
    logic hold_full;     // holding register waits for the shifter
    logic [8:0] transmit_shift_register;     // transmit shift register
    logic tsr_full;      // shifter busy
    logic [3:0] tx_cnt;  // bits presented on the data pin
    logic pin_out;       // data pin output level
    logic pin_oe;        // data pin driven
    logic [8:0] receive_shift_register;     // receive shift register
    logic [3:0] rx_cnt;  // bits sampled so far
    logic [7:0] rcbuf;   // receive buffer
    logic receive_ninth_data;          // received ninth bit
    logic receive_complete_flag;          // receive complete flag
    logic overrun_error;          // overrun error
    logic [7:0] rdata;   // read data, one cycle after the strobe
    logic wake;          // wake request to the core
    logic vector;        // interrupt vector request to the core
  } usss_state_t;

endpackage : usss_pkg

// ### src/usss_top.sv
// synchronous slave serial port: transmit and receive shifting on an
// external shift clock, with status, control and interrupt registers.
// assumes the core drives the register port on this clock and the
// external master owns the shift clock; both pins are asynchronous.
//
// Local design decisions: the address map and strobed register access.
`timescale 1ns/1ps

module usss_top (
  input wire logic clock,
  input wire logic reset,
  input wire usss_pkg::usss_req_t req,
  output logic [usss_pkg::DATA_W-1:0] rdata,
  input wire logic shift_clock_pin,
  input wire logic data_pin_in,
  output logic data_pin_out,
  output logic data_pin_oe,
  output logic wake_request,
  output logic vector_request
);
  import usss_pkg::*;

  // current and next state
  usss_state_t cur_ff;
  usss_state_t nxt_cur;

  // decoded control, all taken from the current state
  logic slave_mode;      // port set up as synchronous slave
  logic rx_on;           // continuous reception running
  logic tx_on;           // transmission allowed
  logic ck_rise;         // rising edge of the synchronised shift clock
  logic ck_fall;         // falling edge of the synchronised shift clock
  logic [3:0] tx_bits;   // length of a transmitted word
  logic [3:0] rx_bits;   // length of a received word
  logic transmit_buffer_empty_flag;            // transmit buffer empty flag
  logic [7:0] flag_read; // flag register as software sees it

  // mode and edge decode
  always_comb begin
    slave_mode = cur_ff.receive_status_control[BIT_PORT_ENABLE] &
                 cur_ff.transmit_status_control[BIT_CLOCKED_MODE] &
                 !cur_ff.transmit_status_control[BIT_CLOCK_SOURCE];
    // single receive enable deliberately plays no part here
    rx_on = slave_mode & cur_ff.receive_status_control[BIT_CONT_RX_EN];
    tx_on = slave_mode & cur_ff.transmit_status_control[BIT_TX_ENABLE];
    // edges are found only from the second stage onward
    ck_rise = !cur_ff.ck_prev & cur_ff.ck_s2;
    ck_fall = cur_ff.ck_prev & !cur_ff.ck_s2;
    tx_bits = cur_ff.transmit_status_control[BIT_TX_NINE] ? BITS_NINE : BITS_EIGHT;
    rx_bits = cur_ff.receive_status_control[BIT_RX_NINE] ? BITS_NINE : BITS_EIGHT;
    // empty flag follows the holding register directly
    transmit_buffer_empty_flag = !cur_ff.hold_full;
    flag_read = cur_ff.flags & MASK_FLAGS_SW;
    flag_read[BIT_RX_COMPLETE] = cur_ff.receive_complete_flag;
    flag_read[BIT_TX_EMPTY] = transmit_buffer_empty_flag;
  end

  // next-state logic for the whole port
  always_comb begin
    nxt_cur = cur_ff;

    // pin synchronisers: two stages before any logic looks
    nxt_cur.ck_s1 = shift_clock_pin;
    nxt_cur.ck_s2 = cur_ff.ck_s1;
    nxt_cur.ck_prev = cur_ff.ck_s2;
    nxt_cur.dt_s1 = data_pin_in;
    nxt_cur.dt_s2 = cur_ff.dt_s1;

    // read data: defined every cycle, zero when no read or unmapped
    nxt_cur.rdata = RESET_BYTE;
    if (req.rd) begin
      unique case (req.addr)
        ADDR_INTERRUPT_CONTROL: begin
          nxt_cur.rdata = cur_ff.interrupt_control;
        end
        ADDR_IRQ_FLAGS_ONE: begin
          nxt_cur.rdata = flag_read;
        end
        ADDR_IRQ_ENABLES_ONE: begin
          nxt_cur.rdata = cur_ff.pie;
        end
        ADDR_IRQ_PRIORITY_ONE: begin
          nxt_cur.rdata = cur_ff.ipr;
        end
        ADDR_RECEIVE_STATUS_CONTROL: begin
          // errors and ninth bit reported beside the control bits
          nxt_cur.rdata = cur_ff.receive_status_control & MASK_RECEIVE_STATUS_CONTROL_SW;
          nxt_cur.rdata[BIT_OVERRUN_ERR] = cur_ff.overrun_error;
          nxt_cur.rdata[BIT_FRAMING_ERR] = 1'b0;
          nxt_cur.rdata[BIT_RX_NINTH_DATA] = cur_ff.receive_ninth_data;
        end
        ADDR_TRANSMIT_STATUS_CONTROL: begin
          nxt_cur.rdata = cur_ff.transmit_status_control & MASK_TRANSMIT_STATUS_CONTROL_SW;
          nxt_cur.rdata[BIT_SHIFT_EMPTY] = !cur_ff.tsr_full;
        end
        ADDR_BAUD_CONTROL: begin
          // bits 5 and 2 have no storage and read zero
          nxt_cur.rdata = cur_ff.baud & MASK_BAUD_SW;
          nxt_cur.rdata[BIT_RX_IDLE] = (cur_ff.rx_cnt == RESET_COUNT);
        end
        ADDR_BAUD_DIVISOR_HIGH: begin
          nxt_cur.rdata = cur_ff.div_hi;
        end
        ADDR_BAUD_DIVISOR_LOW: begin
          nxt_cur.rdata = cur_ff.div_lo;
        end
        ADDR_RECEIVE_BUFFER: begin
          nxt_cur.rdata = cur_ff.rcbuf;
          // reading the buffer clears the flag; a new word below wins
          nxt_cur.receive_complete_flag = 1'b0;
        end
        default: begin
          // holding register is write-only; unmapped reads give zero
          nxt_cur.rdata = RESET_BYTE;
        end
      endcase
    end

    // register writes
    if (req.wr) begin
      unique case (req.addr)
        ADDR_INTERRUPT_CONTROL: begin
          nxt_cur.interrupt_control = req.wdata;
        end
        ADDR_IRQ_FLAGS_ONE: begin
          // our two flags are owned by hardware and ignore writes
          nxt_cur.flags = req.wdata & MASK_FLAGS_SW;
        end
        ADDR_IRQ_ENABLES_ONE: begin
          nxt_cur.pie = req.wdata;
        end
        ADDR_IRQ_PRIORITY_ONE: begin
          nxt_cur.ipr = req.wdata;
        end
        ADDR_RECEIVE_STATUS_CONTROL: begin
          nxt_cur.receive_status_control = req.wdata & MASK_RECEIVE_STATUS_CONTROL_SW;
        end
        ADDR_TRANSMIT_HOLDING: begin
          // ninth bit is taken from the control register now, so it
          // must be set up before the low byte is written
          nxt_cur.hold = {cur_ff.transmit_status_control[BIT_TX_NINTH_DATA], req.wdata};
          nxt_cur.hold_full = 1'b1;
        end
        ADDR_TRANSMIT_STATUS_CONTROL: begin
          nxt_cur.transmit_status_control = req.wdata & MASK_TRANSMIT_STATUS_CONTROL_SW;
        end
        ADDR_BAUD_CONTROL: begin
          nxt_cur.baud = req.wdata & MASK_BAUD_SW;
        end
        ADDR_BAUD_DIVISOR_HIGH: begin
          nxt_cur.div_hi = req.wdata;
        end
        ADDR_BAUD_DIVISOR_LOW: begin
          nxt_cur.div_lo = req.wdata;
        end
        default: begin
          // receive buffer and unmapped addresses ignore writes
          nxt_cur.div_lo = nxt_cur.div_lo;
        end
      endcase
    end

    // transmit path: bits change on rising edges so the master can
    // take them on the falling edge, the same as in master mode
    if (!tx_on) begin
      // disabling drops the word in the shifter; holding word stays
      nxt_cur.tsr_full = 1'b0;
      nxt_cur.tx_cnt = RESET_COUNT;
    end else if (cur_ff.tsr_full) begin
      if (ck_rise && (cur_ff.tx_cnt < tx_bits)) begin
        // least significant bit goes first, ninth bit last
        nxt_cur.pin_out = cur_ff.transmit_shift_register[cur_ff.tx_cnt];
        nxt_cur.tx_cnt = cur_ff.tx_cnt + 4'h1;
      end else if (ck_fall && (cur_ff.tx_cnt == tx_bits)) begin
        // last bit has been taken: the shifter is empty again
        nxt_cur.tsr_full = 1'b0;
        nxt_cur.tx_cnt = RESET_COUNT;
      end
    end else if (cur_ff.hold_full) begin
      // empty shifter takes the waiting word at once; no core clock
      // dependence, so this also runs while the core sleeps
      nxt_cur.transmit_shift_register = cur_ff.hold;
      nxt_cur.tsr_full = 1'b1;
      nxt_cur.tx_cnt = RESET_COUNT;
      // a holding write in this very cycle is a new word and stays
      nxt_cur.hold_full = req.wr && (req.addr == ADDR_TRANSMIT_HOLDING);
    end
    // drive the data pin whenever transmit is enabled, idle or not, and not set up to receive
    nxt_cur.pin_oe = tx_on & !rx_on;

    // receive path: sample on falling edges while continuous receive
    if (!rx_on) begin
      // clearing the enable resets the shifter and clears the errors
      nxt_cur.rx_cnt = RESET_COUNT;
      nxt_cur.overrun_error = 1'b0;
    end else if (ck_fall && !cur_ff.overrun_error) begin
      // overrun holds reception until software clears the enable
      nxt_cur.receive_shift_register[cur_ff.rx_cnt] = cur_ff.dt_s2;
      if (cur_ff.rx_cnt == rx_bits - 4'h1) begin
        nxt_cur.rx_cnt = RESET_COUNT;
        if (nxt_cur.receive_complete_flag) begin
          // buffer still unread: the new word is lost
          nxt_cur.overrun_error = 1'b1;
        end else begin
          // whole word reached the buffer; runs in low-power modes too
          nxt_cur.rcbuf = nxt_cur.receive_shift_register[7:0];
          nxt_cur.receive_ninth_data = cur_ff.receive_status_control[BIT_RX_NINE] & nxt_cur.receive_shift_register[8];
          nxt_cur.receive_complete_flag = 1'b1;
        end
      end else begin
        nxt_cur.rx_cnt = cur_ff.rx_cnt + 4'h1;
      end
    end

    // wake and vector requests toward the core; registered outputs
    nxt_cur.wake = (transmit_buffer_empty_flag & cur_ff.pie[BIT_TX_EMPTY]) |
                   (cur_ff.receive_complete_flag & cur_ff.pie[BIT_RX_COMPLETE]);
    nxt_cur.vector = nxt_cur.wake & cur_ff.interrupt_control[BIT_GLOBAL_IRQ_EN] &
                     cur_ff.interrupt_control[BIT_PERIPH_IRQ_EN];

    // synchronous reset overrides everything above
    if (reset) begin
      nxt_cur = '0;
    end
  end

  // one register for the whole state
  always_ff @(posedge clock) begin
    cur_ff <= nxt_cur;
  end

  // every output comes straight from the state register
  always_comb begin
    rdata = cur_ff.rdata;
    data_pin_out = cur_ff.pin_out;
    data_pin_oe = cur_ff.pin_oe;
    wake_request = cur_ff.wake;
    vector_request = cur_ff.vector;
  end

endmodule : usss_top

// ### verif/tb_top.sv
// bench for the slave serial port: register, transmit and receive runs.
// assumes the checker is bound below and the master model owns the link.
`timescale 1ns/1ps
module tb_top;
  import usss_pkg::*;
  logic clock, reset, data_pin_out, data_pin_oe, wake_request;
  logic vector_request, shift_clock_pin, dt_m, data_line;
  usss_req_t req;
  logic [7:0] rdata;
  logic [8:0] r;
  int err_count, checked;
  always #25 clock = ~clock;
  // shared data wire: the block when enabled, else the master
  assign data_line = data_pin_oe ? data_pin_out : dt_m;
  usss_top usss_top_inst (.clock(clock), .reset(reset), .req(req),
    .rdata(rdata), .shift_clock_pin(shift_clock_pin),
    .data_pin_in(data_line), .data_pin_out(data_pin_out),
    .data_pin_oe(data_pin_oe), .wake_request(wake_request),
    .vector_request(vector_request));
  usss_master_model usss_master_model_inst (.sck(shift_clock_pin),
    .dt_m(dt_m), .dt_line(data_line));
  task tally_and_finish;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  task chk(input string n, input logic [8:0] e, input logic [8:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clock) req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock) req <= '0;
  endtask : wr
  // read, masked compare in the one cycle the data stands
  task rchk(input string n, input logic [3:0] a, input logic [7:0] e,
    input logic [7:0] m = 8'hFF);
    @(posedge clock) req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clock) req <= '0;
    #1 chk(n, {1'b0, e}, {1'b0, rdata & m});
  endtask : rchk
  // frames start off the clock edge, the link is unrelated in phase
  task frame(input int n, input logic [8:0] w, input int s = 0);
    @(posedge clock);
    #7 usss_master_model_inst.xfer(n, w, s, r);
    repeat (8) @(posedge clock);
  endtask : frame
  task wait_wake;
    int i;
    for (i = 0; i < 40 && wake_request !== 1'b1; i++) @(posedge clock);
    chk("wake_request", 9'h001, {8'h00, wake_request});
    if (i == 40) tally_and_finish;
  endtask : wait_wake
  task t_regs;
    rchk("transmit_status_control", ADDR_TRANSMIT_STATUS_CONTROL, 8'h02);
    rchk("flags", ADDR_IRQ_FLAGS_ONE, 8'h10);
    wr(ADDR_BAUD_CONTROL, 8'h24);
    rchk("baud", ADDR_BAUD_CONTROL, 8'h40);
    wr(4'hF, 8'hFF);
    rchk("unmapped", 4'hF, 8'h00);
  endtask : t_regs
  task t_tx;
    wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
    wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h71);
    wr(ADDR_INTERRUPT_CONTROL, 8'hC0);
    wr(ADDR_IRQ_ENABLES_ONE, 8'h10);
    wr(ADDR_TRANSMIT_HOLDING, 8'hA5);
    repeat (3) @(posedge clock);
    wr(ADDR_TRANSMIT_HOLDING, 8'h3C);
    rchk("tx empty", ADDR_IRQ_FLAGS_ONE, 8'h00, 8'h10);
    chk("wake low", 9'h000, {8'h00, wake_request});
    frame(9, 9'h000);
    chk("first word", 9'h1A5, r);
    wait_wake;
    chk("vector", 9'h001, {8'h00, vector_request});
    rchk("busy", ADDR_TRANSMIT_STATUS_CONTROL, 8'h71);
    frame(9, 9'h000, 100);
    chk("second word", 9'h13C, r);
    rchk("idle", ADDR_TRANSMIT_STATUS_CONTROL, 8'h73);
  endtask : t_tx
  task t_rx;
    wr(ADDR_TRANSMIT_STATUS_CONTROL, 8'h10);
    wr(ADDR_IRQ_ENABLES_ONE, 8'h20);
    wr(ADDR_RECEIVE_STATUS_CONTROL, 8'hF0);
    repeat (2) @(posedge clock);
    chk("wake idle", 9'h000, {8'h00, wake_request});
    frame(9, 9'h15A);
    wait_wake;
    chk("rx vector", 9'h001, {8'h00, vector_request});
    rchk("ninth", ADDR_RECEIVE_STATUS_CONTROL, 8'hF1);
    rchk("buffer", ADDR_RECEIVE_BUFFER, 8'h5A);
    rchk("rx flag", ADDR_IRQ_FLAGS_ONE, 8'h10);
  endtask : t_rx
  task t_overrun;
    wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h90);
    frame(8, 9'h081);
    frame(8, 9'h07E, 60);
    rchk("overrun", ADDR_RECEIVE_STATUS_CONTROL, 8'h92, 8'hFE);
    rchk("kept", ADDR_RECEIVE_BUFFER, 8'h81);
    wr(ADDR_RECEIVE_STATUS_CONTROL, 8'h80);
    rchk("cleared", ADDR_RECEIVE_STATUS_CONTROL, 8'h80, 8'hFE);
    wr(ADDR_RECEIVE_STATUS_CONTROL, 8'hA0);
    frame(8, 9'h0C3);
    rchk("single", ADDR_IRQ_FLAGS_ONE, 8'h10);
  endtask : t_overrun
  initial begin
    clock = 1'b0;
    reset = 1'b1;
    req = '0;
    err_count = 0;
    checked = 0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    t_regs;
    t_tx;
    t_rx;
    t_overrun;
    tally_and_finish;
  end
endmodule : tb_top
bind usss_top usss_properties usss_properties_inst (.clock(clock),
  .reset(reset), .req(req), .rdata(rdata),
  .shift_clock_pin(shift_clock_pin), .data_pin_in(data_pin_in),
  .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
  .wake_request(wake_request), .vector_request(vector_request));

// ### verif/usss_master_model.sv
// external master of the link: makes the shift clock and data frames.
// assumes the bench resolves the shared data wire and calls xfer.
`timescale 1ns/1ps
module usss_master_model (
  output logic sck,
  output logic dt_m,
  input wire logic dt_line
);
  // clock stands low between frames
  initial begin
    sck = 1'b0;
    dt_m = 1'b0;
  end
  // one frame lsb first; s stretches the low phase for a slow master
  task xfer(input int n, input logic [8:0] w, input int s,
    output logic [8:0] q);
    q = 9'h000;
    for (int i = 0; i < n; i++) begin
      sck = 1'b1;
      dt_m = w[i];
      #200 sck = 1'b0;
      #(190 + s) q[i] = dt_line;
      #10;
    end
    // released line shows the inverse, not a stale bit
    dt_m = ~w[n-1];
  endtask : xfer
endmodule : usss_master_model

// ### verif/usss_properties.sv
// checker for the slave serial port, bound onto its top module.
// assumes only top ports are visible; it mirrors what software wrote.
`timescale 1ns/1ps
module usss_properties (
  input wire logic clock,
  input wire logic reset,
  input wire usss_pkg::usss_req_t req,
  input wire logic [usss_pkg::DATA_W-1:0] rdata,
  input wire logic shift_clock_pin,
  input wire logic data_pin_in,
  input wire logic data_pin_out,
  input wire logic data_pin_oe,
  input wire logic wake_request,
  input wire logic vector_request
);
  import usss_pkg::*;
  // shadow copies of the control registers
  logic [7:0] receive_status_control_ff, transmit_status_control_ff, pie_ff, interrupt_control_ff;
  logic oe_exp, irq_en, glob_en;
  // shadows follow the write strobe, cleared by reset like the block
  always_ff @(posedge clock) begin
    if (reset) begin
      receive_status_control_ff <= 8'h00;
      transmit_status_control_ff <= 8'h00;
      pie_ff <= 8'h00;
      interrupt_control_ff <= 8'h00;
    end else if (req.wr) begin
      if (req.addr == ADDR_RECEIVE_STATUS_CONTROL) receive_status_control_ff <= req.wdata;
      if (req.addr == ADDR_TRANSMIT_STATUS_CONTROL) transmit_status_control_ff <= req.wdata;
      if (req.addr == ADDR_IRQ_ENABLES_ONE) pie_ff <= req.wdata;
      if (req.addr == ADDR_INTERRUPT_CONTROL) interrupt_control_ff <= req.wdata;
    end
  end
  // pin drive allowed only in slave transmit without receive
  assign oe_exp = transmit_status_control_ff[BIT_TX_ENABLE] & transmit_status_control_ff[BIT_CLOCKED_MODE]
    & !transmit_status_control_ff[BIT_CLOCK_SOURCE] & receive_status_control_ff[BIT_PORT_ENABLE]
    & !receive_status_control_ff[BIT_CONT_RX_EN];
  assign irq_en = pie_ff[BIT_TX_EMPTY] | pie_ff[BIT_RX_COMPLETE];
  assign glob_en = interrupt_control_ff[BIT_GLOBAL_IRQ_EN] & interrupt_control_ff[BIT_PERIPH_IRQ_EN];
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_rd(a);
    req.rd && req.addr == a;
  endsequence
  sequence s_rd_void;
    req.rd && (req.addr > ADDR_RECEIVE_BUFFER
      || req.addr == ADDR_TRANSMIT_HOLDING);
  endsequence
  a_rdata_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  a_void_read: assert property (s_rd_void |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_baud_gaps: assert property (s_rd(ADDR_BAUD_CONTROL)
    |=> rdata[5] == 1'b0 && rdata[2] == 1'b0) else $error("baud gaps set");
  a_receive_status_control_back: assert property (s_rd(ADDR_RECEIVE_STATUS_CONTROL)
    |=> rdata[7:3] == $past(receive_status_control_ff[7:3])) else $error("receive_status_control readback");
  a_oe_mode: assert property (data_pin_oe == $past(oe_exp))
    else $error("data pin enable wrong");
  a_wake_enable: assert property (wake_request |-> $past(irq_en))
    else $error("wake without enable");
  a_vector_wake: assert property (vector_request |-> wake_request)
    else $error("vector without wake");
  a_vector_global: assert property (vector_request |-> $past(glob_en))
    else $error("vector without global enable");
endmodule : usss_properties
